// *** design/lcd_command_display_control.sv ***
// Command interpreter and display state of the dot-matrix LCD driver.
// Assumes an Avalon-MM master on the register port and one 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "lcd_ctrl_regs.svh"
module lcd_command_display_control
  import lcd_ctrl_pkg::*;
#(
  parameter logic [6:0] MAX_MUX = 7'h41,
  parameter logic [3:0] ID_CODE = 4'h5 // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Panel scan
  input wire logic [5:0] scan_row_i,
  input wire logic pixel_bit_i,
  input wire logic pixel_icon_i,
  output logic pixel_on_o,
  output logic row_active_o,
  output logic com_reverse_o,
  // Power and analog settings
  output logic osc_run_o,
  output logic power_run_o,
  output logic drivers_vdd_o,
  output logic static_icon_out_o,
  output logic [3:0] bias_code_o,
  output logic [2:0] temp_compensation_code_o
);

  // ==========================================================
  // State
  bus_ph_t phase_r;
  cmd_st_t cst_r;
  pwr_t pwr_r;
  pwr_t pwr_nxt;
  logic [7:0] pend_r;
  logic serial_r;
  logic rev_r;
  logic disp_on_r;
  logic entire_r;
  logic seg_rev_r;
  logic com_rev_r;
  logic ind_r;
  logic [1:0] ind_mode_r;
  logic rmw_r;
  logic [3:0] page_r;
  logic [7:0] col_r;
  logic [7:0] col_save_r;
  logic [5:0] start_r;
  logic [5:0] contrast_r;
  logic [2:0] ratio_r;
  logic [6:0] mux_r;
  logic lcd_bias_r;
  logic [1:0] ext_bias_r;
  logic quarter_r;
  logic [2:0] tcomp_r;
  logic [3:0] init_cnt_r;
  logic [7:0] op;
  logic [7:0] status;
  logic init_busy;
  logic acc_wr;
  logic acc_rd;
  logic cmd_we;
  logic dat_we;
  logic dat_rd;
  logic op_exec;
  logic arg_exec;
  logic [6:0] eff_row;

  ram_if #(.AW(12), .DW(8)) ram ();

  display_ram #(.AW(12), .DW(8)) u_ram (
    .clk_i(sys_clk_i),
    .ram_port(ram.mem)
  );

  // ==========================================================
  // Helpers
  function automatic logic op_is(input logic [7:0] code);
    return op_exec && (op == code);
  endfunction

  // Saturating column step keeps the pointer on the last column
  function automatic logic [7:0] col_next(input logic [7:0] c);
    return (c >= `COL_MAX) ? c : c + 8'h01;
  endfunction

  // Active rows form a block of mux_r - 1 lines centred in the matrix
  function automatic logic row_hit(input logic [6:0] r);
    logic [6:0] first;
    first = (MAX_MUX - mux_r) >> 1;
    return (r >= first) && (r < first + mux_r - 7'h01);
  endfunction

  // ==========================================================
  // Bus slave: request, fetch cycle, one cycle of waitrequest low
  assign op = writedata_i[7:0];
  assign acc_wr = (phase_r == PH_DONE) && write_i && byteenable_i[0];
  assign acc_rd = (phase_r == PH_DONE) && read_i;
  assign cmd_we = acc_wr && (address_i == `REG_CMD);
  assign dat_we = acc_wr && (address_i == `REG_DATA);
  assign dat_rd = acc_rd && (address_i == `REG_DATA) && !serial_r;
  assign op_exec = cmd_we && (cst_r == ST_OPCODE);
  assign arg_exec = cmd_we && (cst_r == ST_OPERAND);
  assign init_busy = (init_cnt_r != 4'h0);
  assign status = {init_busy, !seg_rev_r, !disp_on_r, init_busy, ID_CODE}; // RULE24

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_r <= PH_IDLE;
      waitrequest_o <= 1'b1;
    end else begin
      case (phase_r)
        PH_IDLE: begin
          if (read_i || write_i)
            phase_r <= PH_FETCH;
        end
        PH_FETCH: begin
          phase_r <= PH_DONE;
          waitrequest_o <= 1'b0;
        end
        default: begin
          phase_r <= PH_IDLE;
          waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (phase_r == PH_FETCH) begin
      if (!read_i)
        readdata_o <= 32'h0000_0000;
      else if (address_i == `REG_CMD)
        readdata_o <= serial_r ? 32'h0000_0000 : {24'h00_0000, status}; // RULE17
      else if (address_i == `REG_DATA)
        readdata_o <= serial_r ? 32'h0000_0000 : {24'h00_0000, ram.rdata};
      else if (address_i == `REG_STATE)
        readdata_o <= {2'h0, start_r, col_r, 2'h0, page_r, pwr_r, ind_mode_r,
                       ind_r, rmw_r, com_rev_r, entire_r, disp_on_r, rev_r};
      else if (address_i == `REG_SET)
        readdata_o <= {8'h00, mux_r, seg_rev_r, lcd_bias_r, ext_bias_r,
                       quarter_r, tcomp_r, ratio_r, contrast_r};
      else if (address_i == `REG_CTRL)
        readdata_o <= {31'h0000_0000, serial_r};
      else
        readdata_o <= 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      serial_r <= 1'b0;
    else if (acc_wr && (address_i == `REG_CTRL))
      serial_r <= writedata_i[0];
  end

  // RAM is addressed by page and column; reads start in the idle phase
  assign ram.addr = {page_r, col_r};
  assign ram.we = dat_we;
  assign ram.wdata = op;
  assign ram.re = (phase_r == PH_IDLE) && read_i && (address_i == `REG_DATA);

  // ==========================================================
  // Command sequencer: opcode byte, optional operand byte
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cst_r <= ST_OPCODE;
      pend_r <= `OP_NO_OPERATION_CMD;
    end else if (cmd_we) begin
      if ((cst_r == ST_OPCODE) && ((op == `OP_CONTRAST) || (op == `OP_IND_ON) || // RULE9
          (op == `OP_MUX) || (op == `OP_BIAS_TCOMP))) begin
        cst_r <= ST_OPERAND;
        pend_r <= op;
      end else begin
        cst_r <= ST_OPCODE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      init_cnt_r <= `INIT_CYCLES;
    else if (op_is(`OP_SW_RESET))
      init_cnt_r <= `INIT_CYCLES;
    else if (init_busy)
      init_cnt_r <= init_cnt_r - 4'h1;
  end

  // ==========================================================
  // Display flags
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rev_r <= 1'b0;
      disp_on_r <= 1'b0;
      entire_r <= 1'b0;
      seg_rev_r <= 1'b0;
    end else begin
      if (op_is(`OP_NORMAL))
        rev_r <= 1'b0;
      if (op_is(`OP_REVERSE))
        rev_r <= 1'b1;
      if (op_is(`OP_DISP_OFF))
        disp_on_r <= 1'b0;
      if (op_is(`OP_DISP_ON))
        disp_on_r <= 1'b1;
      if (op_is(`OP_ALL_OFF))
        entire_r <= 1'b0;
      if (op_is(`OP_ALL_ON))
        entire_r <= 1'b1;
      if (op_is(`OP_SEG_NORM))
        seg_rev_r <= 1'b0;
      if (op_is(`OP_SEG_REV))
        seg_rev_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      com_rev_r <= 1'b0;
      ind_r <= 1'b0;
      ind_mode_r <= 2'h0;
    end else if (op_is(`OP_SW_RESET)) begin
      com_rev_r <= 1'b0; // RULE8
      ind_r <= 1'b0;
    end else begin
      if (op_is(`OP_COM_NORM))
        com_rev_r <= 1'b0; // RULE5
      if (op_is(`OP_COM_REV))
        com_rev_r <= 1'b1;
      if (op_is(`OP_IND_OFF))
        ind_r <= 1'b0;
      if (op_is(`OP_IND_ON))
        ind_r <= 1'b1;
      if (arg_exec && (pend_r == `OP_IND_ON))
        ind_mode_r <= op[1:0]; // RULE9
    end
  end

  // ==========================================================
  // Address pointers and read-modify-write
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      page_r <= 4'h0;
      col_r <= 8'h00;
      col_save_r <= 8'h00;
      start_r <= 6'h00;
      rmw_r <= 1'b0;
    end else if (op_is(`OP_SW_RESET)) begin
      page_r <= 4'h0; // RULE8
      col_r <= 8'h00;
      start_r <= 6'h00;
      rmw_r <= 1'b0;
    end else if (op_exec && (op[7:4] == `NIB_COL_LO)) begin
      col_r <= {col_r[7:4], op[3:0]};
    end else if (op_exec && (op[7:4] == `NIB_COL_HI)) begin
      col_r <= {op[3:0], col_r[3:0]};
    end else if (op_exec && (op[7:4] == `NIB_PAGE)) begin
      if (op[3:0] <= `PAGE_MAX)
        page_r <= op[3:0]; // RULE4
    end else if (op_exec && (op[7:6] == `TOP2_START)) begin
      start_r <= op[5:0];
    end else if (op_is(`OP_RMW)) begin
      rmw_r <= 1'b1; // RULE6
      col_save_r <= col_r;
    end else if (op_is(`OP_RMW_END)) begin
      if (rmw_r)
        col_r <= col_save_r; // RULE7
      rmw_r <= 1'b0;
    end else if (dat_we || (dat_rd && !rmw_r)) begin
      col_r <= col_next(col_r); // RULE6 RULE25
    end
  end

  // ==========================================================
  // Analog settings
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      contrast_r <= `CONTRAST_RST;
      ratio_r <= `RATIO_RST;
      mux_r <= MAX_MUX;
      lcd_bias_r <= 1'b0;
      ext_bias_r <= `EXT_BIAS_RST;
      quarter_r <= 1'b0;
      tcomp_r <= `TCOMP_RST;
    end else if (op_is(`OP_SW_RESET)) begin
      contrast_r <= `CONTRAST_RST; // RULE8
      ratio_r <= `RATIO_RST;
    end else if (op_exec && (op[7:3] == `TOP5_RATIO)) begin
      ratio_r <= op[2:0];
    end else if (op_is(`OP_BIAS_A)) begin
      lcd_bias_r <= 1'b0; // RULE20
    end else if (op_is(`OP_BIAS_B)) begin
      lcd_bias_r <= 1'b1;
    end else if (op_is(`OP_QUARTER_OFF)) begin
      quarter_r <= 1'b0;
    end else if (op_is(`OP_QUARTER_ON)) begin
      quarter_r <= 1'b1; // RULE22
    end else if (arg_exec) begin
      case (pend_r)
        `OP_CONTRAST: contrast_r <= op[5:0];
        `OP_MUX: begin
          if ((op[6:0] >= `MUX_MIN) && (op[6:0] <= MAX_MUX))
            mux_r <= op[6:0]; // RULE18
        end
        `OP_BIAS_TCOMP: begin
          if (op[1:0] != `EXT_BIAS_BAD)
            ext_bias_r <= op[1:0]; // RULE20
          tcomp_r <= op[4:2]; // RULE21
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Power save; the exiting byte also executes, state is kept
  always_comb begin
    pwr_nxt = pwr_r;
    if (cmd_we && (pwr_r != PWR_ACTIVE)) begin
      if ((pwr_r == PWR_STANDBY) && op_is(`OP_SW_RESET))
        pwr_nxt = PWR_SLEEP; // RULE15
      else
        pwr_nxt = PWR_ACTIVE; // RULE16 RULE26
    end
    if ((op_is(`OP_ALL_ON) && !disp_on_r) || (op_is(`OP_DISP_OFF) && entire_r)) // RULE3 RULE12
      pwr_nxt = ind_r ? PWR_STANDBY : PWR_SLEEP; // RULE13 RULE14
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      pwr_r <= PWR_ACTIVE;
    else
      pwr_r <= pwr_nxt;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_run_o <= 1'b1;
      power_run_o <= 1'b1;
      drivers_vdd_o <= 1'b0;
      static_icon_out_o <= 1'b0;
    end else begin
      osc_run_o <= (pwr_r != PWR_SLEEP); // RULE13 RULE14
      power_run_o <= (pwr_r == PWR_ACTIVE);
      drivers_vdd_o <= (pwr_r != PWR_ACTIVE);
      static_icon_out_o <= ind_r && (pwr_r != PWR_SLEEP);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bias_code_o <= 4'h0;
      temp_compensation_code_o <= `TCOMP_RST;
      com_reverse_o <= 1'b0;
    end else begin
      bias_code_o <= {quarter_r, ext_bias_r, lcd_bias_r}; // RULE20 RULE22
      temp_compensation_code_o <= tcomp_r; // RULE21
      com_reverse_o <= com_rev_r; // RULE5
    end
  end

  // ==========================================================
  // Pixel and row output
  // Flipping the row index here makes a scan change visible on the next clock
  assign eff_row = com_rev_r ? (MAX_MUX - 7'h02 - {1'b0, scan_row_i}) : {1'b0, scan_row_i};

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pixel_on_o <= 1'b0;
      row_active_o <= 1'b0;
    end else begin
      row_active_o <= (pwr_r == PWR_ACTIVE) && row_hit(eff_row); // RULE19
      if (pwr_r != PWR_ACTIVE)
        pixel_on_o <= 1'b0;
      else if (entire_r)
        pixel_on_o <= 1'b1; // RULE23
      else if (!disp_on_r)
        pixel_on_o <= 1'b0;
      else if (pixel_icon_i)
        pixel_on_o <= pixel_bit_i; // RULE2
      else
        pixel_on_o <= pixel_bit_i ^ rev_r; // RULE1
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_req;
    (phase_r == PH_IDLE) && (read_i || write_i);
  endsequence
  sequence s_ack;
    !waitrequest_o ##1 waitrequest_o;
  endsequence
  property p_bus_answer;
    s_req |-> ##2 s_ack;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("Bus answer late");

  property p_normal_pixel;
    (pwr_r == PWR_ACTIVE) && disp_on_r && !entire_r && !pixel_icon_i
      |=> pixel_on_o == ($past(pixel_bit_i) ^ $past(rev_r));
  endproperty
  a_normal_pixel: assert property (p_normal_pixel) else $error("Pixel polarity wrong"); // RULE1

  property p_icon_pixel;
    (pwr_r == PWR_ACTIVE) && disp_on_r && !entire_r && pixel_icon_i |=> pixel_on_o == $past(pixel_bit_i);
  endproperty
  a_icon_pixel: assert property (p_icon_pixel) else $error("Icon reversed"); // RULE2

  property p_off_save;
    op_is(`OP_DISP_OFF) && entire_r |=> pwr_r != PWR_ACTIVE;
  endproperty
  a_off_save: assert property (p_off_save) else $error("No power save on display off"); // RULE3

  property p_page;
    page_r <= `PAGE_MAX;
  endproperty
  a_page: assert property (p_page) else $error("Page out of range"); // RULE4

  property p_com_flip;
    op_is(`OP_COM_REV) |-> ##2 com_reverse_o;
  endproperty
  a_com_flip: assert property (p_com_flip) else $error("Scan flip late"); // RULE5

  property p_rmw_read;
    dat_rd && rmw_r && !op_exec |=> $stable(col_r);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("Column moved on read"); // RULE6

  property p_rmw_restore;
    op_is(`OP_RMW_END) && rmw_r |=> col_r == $past(col_save_r) && !rmw_r;
  endproperty
  a_rmw_restore: assert property (p_rmw_restore) else $error("Column not restored"); // RULE7

  property p_sw_reset;
    op_is(`OP_SW_RESET) |=> (col_r == 8'h00) && (page_r == 4'h0) && !rmw_r && !ind_r
      && (contrast_r == `CONTRAST_RST) && (ratio_r == `RATIO_RST);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("Software reset incomplete"); // RULE8

  property p_nop;
    op_is(`OP_NO_OPERATION_CMD) && (pwr_r == PWR_ACTIVE) |=> $stable(col_r) && $stable(page_r) && $stable(rev_r)
      && $stable(disp_on_r) && $stable(pwr_r);
  endproperty
  a_nop: assert property (p_nop) else $error("No-operation changed state"); // RULE10

  sequence s_enter_sleep;
    op_is(`OP_ALL_ON) && !disp_on_r && !ind_r;
  endsequence
  property p_sleep;
    s_enter_sleep |-> ##2 !osc_run_o && drivers_vdd_o && !power_run_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep outputs wrong"); // RULE13

  property p_standby;
    op_is(`OP_ALL_ON) && !disp_on_r && ind_r |-> ##2 osc_run_o && static_icon_out_o && drivers_vdd_o;
  endproperty
  a_standby: assert property (p_standby) else $error("Standby outputs wrong"); // RULE14

  property p_standby_reset;
    (pwr_r == PWR_STANDBY) && op_is(`OP_SW_RESET) |=> pwr_r == PWR_SLEEP;
  endproperty
  a_standby_reset: assert property (p_standby_reset) else $error("Standby reset not sleep"); // RULE15

  property p_exit;
    (pwr_r == PWR_SLEEP) && cmd_we && !op_is(`OP_ALL_ON) && !op_is(`OP_DISP_OFF) |=> pwr_r == PWR_ACTIVE;
  endproperty
  a_exit: assert property (p_exit) else $error("Power save not left"); // RULE16

  property p_col_sat;
    dat_we && (col_r == `COL_MAX) |=> col_r == `COL_MAX;
  endproperty
  a_col_sat: assert property (p_col_sat) else $error("Column wrapped"); // RULE25

endmodule
`default_nettype wire

// *** design/lcd_ctrl_regs.svh ***
// Register offsets, command codes and reset values of the LCD command block.
// Included by the command block design file only; holds definitions only.
//
// Contract
// RULE1: Normal mode lights pixels whose RAM bit is 1; reverse lights bit 0.
// RULE2: Icon line always uses normal polarity.
// RULE3: Display off while entire-display-on is active enters power save.
// RULE4: Page command loads page 0 to 8 for later data accesses.
// RULE5: Common scan direction change flips the running image at once.
// RULE6: Read-modify-write saves column; writes advance column, reads do not.
// RULE7: End of read-modify-write restores the saved column.
// RULE8: Software reset clears modes, addresses, indicator; resistor ratio 4, contrast 20h.
// RULE9: Indicator on takes one mode byte next; indicator off is one byte.
// RULE10: No-operation changes nothing.
// RULE11: Host never sends the test mode command in normal use.
// RULE12: Entire-display-on while display is off enters power save.
// RULE13: Indicator off at entry gives sleep: oscillator and power stop, drivers at supply.
// RULE14: Indicator on at entry gives standby: oscillator and static drive keep running.
// RULE15: Software reset during standby moves to sleep.
// RULE16: A new command byte or hardware reset leaves power save.
// RULE17: Status read only on parallel host port, never in serial mode.
// RULE18: Multiplex ratio accepts 2 up to the variant maximum; rows follow it.
// RULE19: Rows outside the active block show non-selected; block is centred.
// RULE20: Bias other than 1/4 comes from extended setting plus basic bias.
// RULE21: Temperature compensation code held until changed or reset.
// RULE22: Quarter-bias command forces bias 1/4.
// RULE23: Entire-display-on lights every pixel, icon too, over normal/reverse.
// RULE24: Status: busy, segment mapping, display off, init, fixed low nibble.
// RULE25: Column increment saturates at 131.
// RULE26: Leaving power save resumes with retained RAM and settings.
`ifndef LCD_CTRL_REGS_SVH
`define LCD_CTRL_REGS_SVH
`define REG_CMD 5'h00
`define REG_DATA 5'h04
`define REG_STATE 5'h08
`define REG_SET 5'h0C
`define REG_CTRL 5'h10
`define OP_NORMAL 8'hA6
`define OP_REVERSE 8'hA7
`define OP_DISP_OFF 8'hAE
`define OP_DISP_ON 8'hAF
`define OP_ALL_OFF 8'hA4
`define OP_ALL_ON 8'hA5
`define OP_SEG_NORM 8'hA0
`define OP_SEG_REV 8'hA1
`define OP_BIAS_A 8'hA2
`define OP_BIAS_B 8'hA3
`define OP_COM_NORM 8'hC0
`define OP_COM_REV 8'hC8
`define OP_RMW 8'hE0
`define OP_RMW_END 8'hEE
`define OP_SW_RESET 8'hE2
`define OP_NO_OPERATION_CMD 8'hE3
`define OP_IND_OFF 8'hAC
`define OP_IND_ON 8'hAD
`define OP_CONTRAST 8'h81
`define OP_MUX 8'hA8
`define OP_BIAS_TCOMP 8'hA9
`define OP_QUARTER_OFF 8'hAA
`define OP_QUARTER_ON 8'hAB
`define NIB_COL_LO 4'h0
`define NIB_COL_HI 4'h1
`define NIB_PAGE 4'hB
`define TOP5_RATIO 5'h04
`define TOP2_START 2'h1
`define PAGE_MAX 4'h8
`define COL_MAX 8'h83
`define CONTRAST_RST 6'h20
`define RATIO_RST 3'h4
`define TCOMP_RST 3'h0
`define EXT_BIAS_RST 2'h0
`define EXT_BIAS_BAD 2'h3
`define MUX_MIN 7'h02
`define INIT_CYCLES 4'hF
`endif

// *** design/lcd_ctrl_pkg.sv ***
// Types shared by the LCD command block.
// Assumes nothing of its surroundings.
package lcd_ctrl_pkg;
  typedef enum logic [1:0] {PWR_ACTIVE = 2'b00, PWR_STANDBY = 2'b01, PWR_SLEEP = 2'b11} pwr_t;
  typedef enum logic {ST_OPCODE = 1'b0, ST_OPERAND = 1'b1} cmd_st_t;
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_FETCH = 2'b01, PH_DONE = 2'b11} bus_ph_t;
endpackage

// *** design/ram_if.sv ***
// Port bundle between the command block and its display RAM.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface ram_if #(parameter int AW = 12, parameter int DW = 8);
  logic we;
  logic re;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** design/display_ram.sv ***
// Display RAM: one write and one read per cycle, registered read data.
// Assumes address and strobes are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module display_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk_i,
  // Access port
  ram_if.mem ram_port
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // No reset: contents survive power save and are undefined after power-up
  always_ff @(posedge clk_i) begin
    if (ram_port.we)
      mem_r[ram_port.addr] <= ram_port.wdata;
    if (ram_port.re)
      ram_port.rdata <= mem_r[ram_port.addr];
  end
endmodule
`default_nettype wire

// *** tb/lcd_host_model.sv ***
// Host microcontroller model: Avalon-MM master facing the command block.
// Assumes one clock and a slave that drops waitrequest for one cycle.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Avalon-MM master
  output logic [4:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [3:0] byteenable_o,
  output logic [31:0] writedata_o,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i
);
  // ==========================================
  // Bus cycles
  initial begin
    address_o = 5'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    byteenable_o = 4'hF;
    writedata_o = 32'h0000_0000;
  end

  // Only documented opcodes are ever sent; the factory test command never leaves here.
  task automatic access(input logic [4:0] a, input logic rd, input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    address_o <= a;
    read_o <= rd;
    write_o <= !rd;
    writedata_o <= {24'h00_0000, d};
    do @(posedge sys_clk_i); while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/lcd_command_display_control_tb.sv ***
// Self-checking bench of the LCD command block.
// Assumes the host model as Avalon master and a 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module lcd_command_display_control_tb;
  import lcd_ctrl_pkg::*;
  logic sys_clk_i, rstn_i, read_w, write_w, pixel_bit_i, pixel_icon_i, waitrequest_o, pixel_on_o;
  logic row_active_o, com_reverse_o, osc_run_o, power_run_o, drivers_vdd_o, static_icon_out_o;
  logic [4:0] address_w;
  logic [3:0] be_w, bias_code_o;
  logic [31:0] wdata_w, readdata_o, rv, sv;
  logic [5:0] scan_row_i;
  logic [2:0] temp_compensation_code_o;
  int errors, cmp_count;

  lcd_host_model lcd_host_model_inst (.sys_clk_i(sys_clk_i), .address_o(address_w), .read_o(read_w),
    .write_o(write_w), .byteenable_o(be_w), .writedata_o(wdata_w), .readdata_i(readdata_o),
    .waitrequest_i(waitrequest_o));
  lcd_command_display_control lcd_command_display_control_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .address_i(address_w), .read_i(read_w), .write_i(write_w), .byteenable_i(be_w), .writedata_i(wdata_w),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .scan_row_i(scan_row_i),
    .pixel_bit_i(pixel_bit_i), .pixel_icon_i(pixel_icon_i), .pixel_on_o(pixel_on_o),
    .row_active_o(row_active_o), .com_reverse_o(com_reverse_o), .osc_run_o(osc_run_o),
    .power_run_o(power_run_o), .drivers_vdd_o(drivers_vdd_o), .static_icon_out_o(static_icon_out_o),
    .bias_code_o(bias_code_o), .temp_compensation_code_o(temp_compensation_code_o));

  // ==========================================
  // Helpers
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    lcd_host_model_inst.access(a, 1'b0, d, rv);
  endtask
  task rd(input logic [4:0] a);
    lcd_host_model_inst.access(a, 1'b1, 8'h00, rv);
  endtask
  task cmd(input logic [7:0] d);
    wr(5'h00, d);
  endtask
  // Registered outputs lag the write edge by one more cycle
  task settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task pin(input logic [5:0] r, input logic b, input logic i);
    @(posedge sys_clk_i);
    scan_row_i <= r;
    pixel_bit_i <= b;
    pixel_icon_i <= i;
    settle();
  endtask

  // ==========================================
  // Scenarios
  task t_pixel;
    cmd(8'hAF);
    cmd(8'hA6);
    pin(6'd32, 1'b1, 1'b0); chk(pixel_on_o, 1);
    cmd(8'hA7);
    pin(6'd32, 1'b0, 1'b0); chk(pixel_on_o, 1);
    pin(6'd32, 1'b1, 1'b1); chk(pixel_on_o, 1);
    cmd(8'hA5);
    pin(6'd32, 1'b1, 1'b0); chk(pixel_on_o, 1);
    cmd(8'hAE);
    settle(); chk({osc_run_o, power_run_o, drivers_vdd_o}, 3'b001);
    $display("test pixel done");
  endtask
  task t_power;
    cmd(8'hE3);
    settle(); chk({osc_run_o, power_run_o, drivers_vdd_o}, 3'b110);
    cmd(8'hAD);
    cmd(8'h01);
    cmd(8'hA5);
    settle(); chk({osc_run_o, power_run_o, drivers_vdd_o, static_icon_out_o}, 4'b1011);
    cmd(8'hE2);
    settle(); chk({osc_run_o, power_run_o, static_icon_out_o}, 3'b000);
    cmd(8'hE3);
    settle(); chk(power_run_o, 1);
    rd(5'h08); chk(rv[2:0], 3'b101);
    cmd(8'hAF);
    cmd(8'hA4);
    $display("test power done");
  endtask
  task t_rmw;
    cmd(8'hB3);
    cmd(8'h05);
    cmd(8'h10);
    cmd(8'hE0);
    rd(5'h04);
    wr(5'h04, 8'h5A);
    rd(5'h08); chk({rv[23:16], rv[13:10]}, 12'h063);
    cmd(8'hEE);
    rd(5'h08); chk({rv[23:16], rv[4]}, 9'h0A);
    rd(5'h04); chk(rv[7:0], 8'h5A);
    cmd(8'hB8);
    cmd(8'hB9);
    cmd(8'h02);
    cmd(8'h18);
    wr(5'h04, 8'h11);
    wr(5'h04, 8'h22);
    rd(5'h08); chk({rv[23:16], rv[13:10]}, 12'h838);
    $display("test rmw done");
  endtask
  task t_reset;
    cmd(8'hC8);
    settle(); chk(com_reverse_o, 1);
    cmd(8'h81);
    cmd(8'h3F);
    cmd(8'h45);
    cmd(8'h22);
    cmd(8'hE0);
    cmd(8'hE2);
    settle(); chk(com_reverse_o, 0);
    rd(5'h08); chk({rv[29:16], rv[13:10], rv[5:3]}, 0);
    rd(5'h0C); chk(rv[8:0], {3'h4, 6'h20});
    $display("test reset done");
  endtask
  task t_misc;
    rd(5'h08);
    sv = rv;
    cmd(8'hE3);
    rd(5'h08); chk(rv, sv);
    cmd(8'hA9);
    cmd(8'h1D);
    settle(); chk({bias_code_o, temp_compensation_code_o}, 7'h17);
    cmd(8'hAB);
    settle(); chk(bias_code_o[3], 1);
    cmd(8'hA8);
    cmd(8'h10);
    cmd(8'hA8);
    cmd(8'h01);
    rd(5'h0C); chk(rv[23:17], 7'h10);
    pin(6'd0, 1'b0, 1'b0); chk(row_active_o, 0);
    pin(6'd32, 1'b0, 1'b0); chk(row_active_o, 1);
    rd(5'h00); chk(rv[7:0], 8'h45);
    wr(5'h10, 8'h01);
    rd(5'h00); chk(rv, 0);
    wr(5'h10, 8'h00);
    cmd(8'hA1);
    cmd(8'hA3);
    rd(5'h00); chk(rv[7:0], 8'h05);
    settle(); chk(bias_code_o, 4'hB);
    $display("test misc done");
  endtask
  // Hardware reset in mid-run must pull the block out of sleep
  task t_hw_reset;
    cmd(8'hAE);
    cmd(8'hA5);
    settle(); chk(osc_run_o, 0);
    @(posedge sys_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    settle(); chk({osc_run_o, power_run_o, drivers_vdd_o}, 3'b110);
    $display("test hw reset done");
  endtask

  // ==========================================
  // Sequence and verdict
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    rstn_i = 1'b0;
    scan_row_i = 6'd0;
    pixel_bit_i = 1'b0;
    pixel_icon_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    t_pixel();
    t_power();
    t_rmw();
    t_reset();
    t_misc();
    t_hw_reset();
    complete_run();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
